// [mft_fault_cfg.sv]
`timescale 1ns/1ps
`default_nettype none
module mft_fault_cfg (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire mft_pkg::mft_bus_t i_bus,
	output logic [31:0] o_rdata,
	input wire mft_pkg::mft_meas_t i_meas,
	input wire logic i_cycle_done,
	input wire logic i_sync_lost,
	input wire logic i_running,
	input wire logic i_retry_attempt,
	output logic o_ov_fault,
	output logic o_uv_fault,
	output logic o_lock_fault,
	output logic o_retry_block,
	output logic o_target_zero,
	output logic o_irq
);

	// ****************************************
	// Register file
	// ****************************************
	logic [31:0] fault_q;
	logic [31:0] pin1_q;
	logic [31:0] pin2_q;
	logic [31:0] periph_q;
	logic [mft_pkg::ST_W-1:0] ien_q;
	logic [mft_pkg::ST_W-1:0] stat_q;
	logic [mft_pkg::ST_W-1:0] stat_d;
	logic [mft_pkg::ST_W-1:0] clr_w;
	logic [31:0] rdata_q;
	logic wr_clr;
	mft_pkg::mft_thr_t thr;

	assign wr_clr = i_bus.wr && (i_bus.addr == mft_pkg::OFS_CLR);
	assign clr_w = wr_clr ? i_bus.wdata[mft_pkg::ST_W-1:0] : '0;

	// Writes to OFS_STAT or unmapped offsets are dropped; OFS_CLR writes act only through clr_w
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fault_q <= mft_pkg::RST_FAULT;
			pin1_q <= mft_pkg::RST_PIN1;
			pin2_q <= mft_pkg::RST_PIN2;
			periph_q <= mft_pkg::RST_PERIPH;
			ien_q <= '0;
		end else if (i_bus.wr) begin
			case (i_bus.addr)
				mft_pkg::OFS_FAULT: fault_q <= i_bus.wdata;
				mft_pkg::OFS_PIN1: pin1_q <= i_bus.wdata;
				mft_pkg::OFS_PIN2: pin2_q <= i_bus.wdata;
				mft_pkg::OFS_PERIPH: periph_q <= i_bus.wdata;
				mft_pkg::OFS_IEN: ien_q <= i_bus.wdata[mft_pkg::ST_W-1:0];
				default: ien_q <= ien_q;
			endcase
		end
	end

	// Read data valid only the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_q <= 32'h0000_0000;
		end else if (i_bus.rd) begin
			case (i_bus.addr)
				mft_pkg::OFS_FAULT: rdata_q <= fault_q;
				mft_pkg::OFS_PIN1: rdata_q <= pin1_q;
				mft_pkg::OFS_PIN2: rdata_q <= pin2_q;
				mft_pkg::OFS_PERIPH: rdata_q <= periph_q;
				mft_pkg::OFS_STAT: rdata_q <= {25'h0, stat_q};
				mft_pkg::OFS_IEN: rdata_q <= {25'h0, ien_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign o_rdata = rdata_q;

	mft_thr_decode u_dec (
		.i_cfg(fault_q),
		.o_thr(thr)
	);

	// ****************************************
	// Supply window
	// ****************************************
	logic ov_cond;
	logic uv_cond;
	logic ov_q;
	logic uv_q;

	assign ov_cond = (thr.ov_dv != 10'h000) && (i_meas.vm_dv > thr.ov_dv);
	assign uv_cond = (thr.uv_dv != 10'h000) && (i_meas.vm_dv < thr.uv_dv);

	// Condition wins over a clear in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ov_q <= 1'b0;
		end else if (ov_cond) begin
			ov_q <= 1'b1;
		end else if (fault_q[mft_pkg::F_OV_MODE] || clr_w[mft_pkg::ST_OV]) begin
			ov_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			uv_q <= 1'b0;
		end else if (uv_cond) begin
			uv_q <= 1'b1;
		end else if (fault_q[mft_pkg::F_UV_MODE] || clr_w[mft_pkg::ST_UV]) begin
			uv_q <= 1'b0;
		end
	end

	assign o_ov_fault = ov_q;
	assign o_uv_fault = uv_q;

	// ****************************************
	// Lock detection
	// ****************************************
	logic [15:0] prev_q;
	logic [19:0] prev_x;
	logic [19:0] cur_x;
	logic ratio_hit;
	logic abn_ev;
	logic sync_ev;
	logic nomtr_ev;
	logic minspd_ev;
	logic [3:0] sync_cnt_q;
	logic lock_q;

	// First cycle after reset has no reference, so no ratio check
	assign prev_x = 20'({4'h0, prev_q} * thr.ratio);
	assign cur_x = 20'({4'h0, i_meas.speed_dhz} * thr.ratio);
	assign ratio_hit = (prev_q != 16'h0000)
		&& (({4'h0, i_meas.speed_dhz} > prev_x) || ({4'h0, prev_q} > cur_x));
	assign abn_ev = fault_q[mft_pkg::F_ABN_EN] && i_cycle_done
		&& ((i_meas.speed_dhz > thr.abn_dhz) || ratio_hit);
	assign sync_ev = fault_q[mft_pkg::F_SYNC_EN] && i_sync_lost
		&& ((sync_cnt_q + 4'h1) >= thr.sync_max);
	assign nomtr_ev = fault_q[mft_pkg::F_NOMTR_EN] && i_running && i_cycle_done
		&& (i_meas.shunt_dmv < thr.nomtr_dmv);
	assign minspd_ev = i_running && i_cycle_done
		&& (i_meas.speed_dhz < thr.minspd_dhz);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prev_q <= 16'h0000;
		end else if (!i_running) begin
			prev_q <= 16'h0000;
		end else if (i_cycle_done) begin
			prev_q <= i_meas.speed_dhz;
		end
	end

	// Count restarts when stopped, disabled or after a fault
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_cnt_q <= 4'h0;
		end else if (!i_running || !fault_q[mft_pkg::F_SYNC_EN] || sync_ev) begin
			sync_cnt_q <= 4'h0;
		end else if (i_sync_lost) begin
			sync_cnt_q <= sync_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lock_q <= 1'b0;
		end else begin
			lock_q <= abn_ev || sync_ev || nomtr_ev || minspd_ev;
		end
	end

	assign o_lock_fault = lock_q;

	// ****************************************
	// Retry limit and zero duty
	// ****************************************
	logic [4:0] retry_cnt_q;
	logic block_q;
	logic zero_q;

	// Counter saturates so a long retry run cannot wrap
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			retry_cnt_q <= 5'h00;
		end else if (i_retry_attempt && retry_cnt_q != 5'h1F) begin
			retry_cnt_q <= retry_cnt_q + 5'h01;
		end else if (clr_w[mft_pkg::ST_RETRY]) begin
			retry_cnt_q <= 5'h00;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			block_q <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			block_q <= (thr.retry_max != 5'h00) && (retry_cnt_q >= thr.retry_max);
			zero_q <= i_meas.duty_dpct < thr.duty_dpct;
		end
	end

	assign o_retry_block = block_q;
	assign o_target_zero = zero_q;

	// ****************************************
	// Interrupt status
	// ****************************************
	always_comb begin
		stat_d = stat_q & ~clr_w;
		stat_d[mft_pkg::ST_OV] = stat_d[mft_pkg::ST_OV] | ov_cond;
		stat_d[mft_pkg::ST_UV] = stat_d[mft_pkg::ST_UV] | uv_cond;
		stat_d[mft_pkg::ST_ABN] = stat_d[mft_pkg::ST_ABN] | abn_ev;
		stat_d[mft_pkg::ST_SYNC] = stat_d[mft_pkg::ST_SYNC] | sync_ev;
		stat_d[mft_pkg::ST_NOMTR] = stat_d[mft_pkg::ST_NOMTR] | nomtr_ev;
		stat_d[mft_pkg::ST_MINSPD] = stat_d[mft_pkg::ST_MINSPD] | minspd_ev;
		stat_d[mft_pkg::ST_RETRY] = stat_d[mft_pkg::ST_RETRY] | block_q;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stat_q <= '0;
		end else begin
			stat_q <= stat_d;
		end
	end

	assign o_irq = |(stat_q & ien_q);

	// ****************************************
	// Checks
	// ****************************************
	a_ov_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		ov_q && !ov_cond && !fault_q[mft_pkg::F_OV_MODE] && !clr_w[mft_pkg::ST_OV]
		|=> ov_q) else $error("latched overvoltage dropped");
	a_ov_auto_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!ov_cond && fault_q[mft_pkg::F_OV_MODE] |=> !ov_q)
		else $error("overvoltage not auto-cleared");
	a_uv_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		uv_q && !uv_cond && !fault_q[mft_pkg::F_UV_MODE] && !clr_w[mft_pkg::ST_UV]
		|=> uv_q) else $error("latched undervoltage dropped");
	a_ov_ceiling: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fault_q[mft_pkg::F_OV +: 3] == 3'h1 && i_meas.vm_dv == 10'h065 |=> ov_q)
		else $error("ceiling of 10 V not applied");
	a_uv_floor: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fault_q[mft_pkg::F_UV +: 3] == 3'h1 && i_meas.vm_dv == 10'h031 |=> uv_q)
		else $error("floor of 5 V not applied");
	a_abn_speed_thr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fault_q[mft_pkg::F_ABN_EN] && i_cycle_done && fault_q[mft_pkg::F_ABN_THR +: 4] == 4'hF
		&& i_meas.speed_dhz > 16'h9C40 |=> lock_q && stat_q[mft_pkg::ST_ABN])
		else $error("abnormal speed above 4000 Hz missed");
	a_sync_count: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		sync_ev |-> (sync_cnt_q == thr.sync_max - 4'h1) ##1 (sync_cnt_q == 4'h0))
		else $error("sync-loss fault at wrong count");
	a_detect_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!fault_q[mft_pkg::F_SYNC_EN] && !fault_q[mft_pkg::F_ABN_EN]
		&& !fault_q[mft_pkg::F_NOMTR_EN] |-> !sync_ev && !abn_ev && !nomtr_ev)
		else $error("disabled detection fired");
	a_retry_limit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fault_q[mft_pkg::F_RETRY +: 3] == 3'h0 |=> !block_q)
		else $error("unlimited retries blocked");
	a_zero_duty: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fault_q[mft_pkg::F_DUTY +: 2] == 2'h3 && i_meas.duty_dpct == 10'h018 |=> zero_q)
		else $error("duty below 2.5 percent not zeroed");
	a_min_speed: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_running && i_cycle_done && i_meas.speed_dhz < 16'h0005 |=> lock_q)
		else $error("stall below minimum speed missed");
	a_read_reserved: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_bus.rd && i_bus.addr == 8'hA7 |=> o_rdata == 32'h0000_0000)
		else $error("reserved offset read nonzero");

	// Table spot checks, plus UV auto-clear and sync count when disabled
	a_uv_auto_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!uv_cond && fault_q[mft_pkg::F_UV_MODE] |=> !uv_q)
		else $error("undervoltage not auto-cleared");
	a_nomtr_thr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fault_q[mft_pkg::F_NOMTR_EN] && i_running && i_cycle_done && fault_q[mft_pkg::F_NOMTR +: 3]
		== 3'h0 && i_meas.shunt_dmv == 12'h031 |=> lock_q) else $error("absent motor missed");
	a_ratio_limit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fault_q[mft_pkg::F_ABN_EN] && i_cycle_done && fault_q[mft_pkg::F_RATIO +: 2] == 2'h0
		&& prev_q == 16'h03E8 && i_meas.speed_dhz == 16'h07D1 |=> lock_q) else $error("ratio missed");
	a_retry_block: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fault_q[mft_pkg::F_RETRY +: 3] == 3'h1 && retry_cnt_q == 5'h02 |=> block_q)
		else $error("retry limit of 2 not applied");
	a_abn_thr_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fault_q[mft_pkg::F_ABN_EN] && i_cycle_done && fault_q[mft_pkg::F_ABN_THR +: 4] == 4'h0
		&& i_meas.speed_dhz == 16'h09C5 |=> lock_q) else $error("speed above 250 Hz missed");
	a_min_speed_top: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_running && i_cycle_done && fault_q[mft_pkg::F_MINSPD +: 3] == 3'h7
		&& i_meas.speed_dhz == 16'h00F9 |=> lock_q) else $error("stall below 25 Hz missed");
	a_sync_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!fault_q[mft_pkg::F_SYNC_EN] |=> sync_cnt_q == 4'h0)
		else $error("sync count kept while disabled");

	// Clears, stickiness and idle read
	a_read_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!i_bus.rd |=> o_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	a_stat_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		stat_q[mft_pkg::ST_SYNC] && !clr_w[mft_pkg::ST_SYNC] |=> stat_q[mft_pkg::ST_SYNC])
		else $error("sync status dropped without clear");
	a_ov_clear_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		ov_q && !ov_cond && clr_w[mft_pkg::ST_OV] |=> !ov_q)
		else $error("latched overvoltage not cleared");
	a_uv_clear_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		uv_q && !uv_cond && clr_w[mft_pkg::ST_UV] |=> !uv_q)
		else $error("latched undervoltage not cleared");

endmodule
`default_nettype wire

// [mft_pkg.sv]
package mft_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFS_FAULT = 8'h94;
	localparam logic [7:0] OFS_PIN1 = 8'hA6;
	localparam logic [7:0] OFS_PIN2 = 8'hA8;
	localparam logic [7:0] OFS_PERIPH = 8'hAA;
	localparam logic [7:0] OFS_STAT = 8'hB0;
	localparam logic [7:0] OFS_CLR = 8'hB4;
	localparam logic [7:0] OFS_IEN = 8'hB8;
	localparam logic [31:0] RST_FAULT = 32'h0000_0000;
	localparam logic [31:0] RST_PIN1 = 32'h0000_0000;
	localparam logic [31:0] RST_PIN2 = 32'h0600_0000;
	localparam logic [31:0] RST_PERIPH = 32'h0000_2000;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int unsigned F_ABN_EN = 30;
	localparam int unsigned F_SYNC_EN = 29;
	localparam int unsigned F_NOMTR_EN = 28;
	localparam int unsigned F_ABN_THR = 24;
	localparam int unsigned F_SYNC_CNT = 21;
	localparam int unsigned F_NOMTR = 18;
	localparam int unsigned F_OV_MODE = 17;
	localparam int unsigned F_OV = 14;
	localparam int unsigned F_UV_MODE = 13;
	localparam int unsigned F_UV = 10;
	localparam int unsigned F_RETRY = 7;
	localparam int unsigned F_MINSPD = 4;
	localparam int unsigned F_RATIO = 2;
	localparam int unsigned F_DUTY = 0;

	// Status, clear and enable share this layout
	localparam int unsigned ST_OV = 0;
	localparam int unsigned ST_UV = 1;
	localparam int unsigned ST_ABN = 2;
	localparam int unsigned ST_SYNC = 3;
	localparam int unsigned ST_NOMTR = 4;
	localparam int unsigned ST_MINSPD = 5;
	localparam int unsigned ST_RETRY = 6;
	localparam int unsigned ST_W = 7;

	// ****************************************
	// Threshold tables (0.1 Hz, 0.1 mV, 0.1 V, 0.1 %)
	// ****************************************
	localparam logic [15:0] ABN_STEP_DHZ = 16'h09C4;
	localparam logic [3:0] SYNC_BASE = 4'h2;
	localparam logic [7:0][15:0] MINSPD_DHZ = {16'h00FA, 16'h0096, 16'h0064, 16'h0032,
		16'h001E, 16'h0014, 16'h000A, 16'h0005};
	localparam logic [7:0][11:0] NOMTR_DMV = {12'h190, 12'h12C, 12'h0FA, 12'h0C8,
		12'h07D, 12'h064, 12'h04B, 12'h032};
	localparam logic [7:0][9:0] OV_DV = {10'h258, 10'h1F4, 10'h190, 10'h140,
		10'h0DC, 10'h096, 10'h064, 10'h000};
	localparam logic [7:0][9:0] UV_DV = {10'h096, 10'h078, 10'h064, 10'h050,
		10'h046, 10'h03C, 10'h032, 10'h000};
	localparam logic [7:0][4:0] RETRY_MAX = {5'h14, 5'h0F, 5'h0A, 5'h07,
		5'h05, 5'h03, 5'h02, 5'h00};
	localparam logic [3:0][3:0] RATIO_LIM = {4'h8, 4'h6, 4'h4, 4'h2};
	localparam logic [3:0][9:0] DUTY_DPCT = {10'h019, 10'h014, 10'h00A, 10'h000};

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} mft_bus_t;

	typedef struct packed {
		logic [15:0] speed_dhz;
		logic [11:0] shunt_dmv;
		logic [9:0] vm_dv;
		logic [9:0] duty_dpct;
	} mft_meas_t;

	typedef struct packed {
		logic [15:0] abn_dhz;
		logic [15:0] minspd_dhz;
		logic [11:0] nomtr_dmv;
		logic [9:0] ov_dv;
		logic [9:0] uv_dv;
		logic [4:0] retry_max;
		logic [3:0] ratio;
		logic [9:0] duty_dpct;
		logic [3:0] sync_max;
	} mft_thr_t;

endpackage

// [mft_thr_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module mft_thr_decode (
	input wire logic [31:0] i_cfg,
	output mft_pkg::mft_thr_t o_thr
);

	// ****************************************
	// Code to threshold lookup
	// ****************************************
	logic [4:0] abn_mult;

	assign abn_mult = {1'b0, i_cfg[mft_pkg::F_ABN_THR +: 4]} + 5'h01;
	assign o_thr.abn_dhz = 16'(abn_mult * mft_pkg::ABN_STEP_DHZ);
	assign o_thr.sync_max = {1'b0, i_cfg[mft_pkg::F_SYNC_CNT +: 3]}
		+ mft_pkg::SYNC_BASE;
	// Current equals this voltage over amplifier gain times shunt
	assign o_thr.nomtr_dmv = mft_pkg::NOMTR_DMV[i_cfg[mft_pkg::F_NOMTR +: 3]];
	assign o_thr.ov_dv = mft_pkg::OV_DV[i_cfg[mft_pkg::F_OV +: 3]];
	assign o_thr.uv_dv = mft_pkg::UV_DV[i_cfg[mft_pkg::F_UV +: 3]];
	assign o_thr.retry_max = mft_pkg::RETRY_MAX[i_cfg[mft_pkg::F_RETRY +: 3]];
	assign o_thr.minspd_dhz = mft_pkg::MINSPD_DHZ[i_cfg[mft_pkg::F_MINSPD +: 3]];
	assign o_thr.ratio = mft_pkg::RATIO_LIM[i_cfg[mft_pkg::F_RATIO +: 2]];
	assign o_thr.duty_dpct = mft_pkg::DUTY_DPCT[i_cfg[mft_pkg::F_DUTY +: 2]];

endmodule
`default_nettype wire

// [mft_fault_cfg_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mft_fault_cfg_tb;
	// ****************************************
	// Signals
	// ****************************************
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} mft_tb_row_t;
	localparam int LIMIT = 20000;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	mft_pkg::mft_bus_t bus = '0;
	mft_pkg::mft_meas_t meas = '{speed_dhz: 16'h03E8, shunt_dmv: 12'hFFF,
		vm_dv: 10'h0F0, duty_dpct: 10'h1F4};
	logic cyc = 1'b0, slost = 1'b0, retry = 1'b0, run = 1'b0;
	logic [31:0] rdata;
	logic ov, uv, lock, rblk, tz, irq;
	int miscompares = 0, compares = 0, cycles = 0;
	int ms[8] = '{5, 10, 20, 30, 50, 100, 150, 250};
	int nm[8] = '{50, 75, 100, 125, 200, 250, 300, 400};
	int ovt[8] = '{0, 100, 150, 220, 320, 400, 500, 600};
	int uvt[8] = '{0, 50, 60, 70, 80, 100, 120, 150};
	int rt[8] = '{0, 2, 3, 5, 7, 10, 15, 20};
	int dt[4] = '{0, 10, 20, 25};
	// Status writes and unmapped places must read back as zero
	mft_tb_row_t rows[10] = '{
		'{8'h94, 32'hFFFF_FFFF, 32'hFFFF_FFFF}, '{8'hA6, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
		'{8'hA8, 32'h1234_5678, 32'h1234_5678}, '{8'hAA, 32'h8765_4321, 32'h8765_4321},
		'{8'hB8, 32'hFFFF_FFFF, 32'h0000_007F}, '{8'hB0, 32'hFFFF_FFFF, 32'h0000_0000},
		'{8'hB4, 32'h0000_007F, 32'h0000_0000}, '{8'hA7, 32'hFFFF_FFFF, 32'h0000_0000},
		'{8'h94, 32'h0000_0000, 32'h0000_0000}, '{8'hB8, 32'h0000_0000, 32'h0000_0000}};

	mft_fault_cfg uut (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_bus(bus),
		.o_rdata(rdata),
		.i_meas(meas),
		.i_cycle_done(cyc),
		.i_sync_lost(slost),
		.i_running(run),
		.i_retry_attempt(retry),
		.o_ov_fault(ov),
		.o_uv_fault(uv),
		.o_lock_fault(lock),
		.o_retry_block(rblk),
		.o_target_zero(tz),
		.o_irq(irq)
	);

	always #25 i_clk = ~i_clk;

	// ****************************************
	// Helpers
	// ****************************************
	task automatic conclude();
		if (miscompares == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Cut a hang short rather than run forever
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			conclude();
		end
	end

	task automatic chk(input string m, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	function automatic logic [31:0] f(input int v, input int unsigned p);
		return 32'(v) << p;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		bus <= '0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		bus <= '0;
		#1;
		chk("read", rdata, e);
	endtask

	// One event pulse; the lock output stands one cycle after it
	task automatic ev(input logic [2:0] w, input logic [15:0] s, input logic [11:0] sh,
		input logic e);
		@(posedge i_clk);
		meas.speed_dhz <= s;
		meas.shunt_dmv <= sh;
		{cyc, slost, retry} <= w;
		@(posedge i_clk);
		{cyc, slost, retry} <= 3'h0;
		#1;
		chk("lock", {31'h0, lock}, {31'h0, e});
	endtask

	task automatic lvl(input int v, input int d, input logic [2:0] e);
		@(posedge i_clk);
		meas.vm_dv <= 10'(v);
		meas.duty_dpct <= 10'(d);
		repeat (2) @(posedge i_clk);
		#1;
		chk("level", {29'h0, ov, uv, tz}, {29'h0, e});
	endtask

	// Dropping run forgets the previous cycle speed
	task automatic clr_prev();
		@(posedge i_clk);
		run <= 1'b0;
		@(posedge i_clk);
		run <= 1'b1;
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'b1;
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d);
			rd(rows[k].a, rows[k].e);
		end
		wr(mft_pkg::OFS_FAULT, 32'hFFFF_FFFF);
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		#1;
		chk("reset", {26'h0, ov, uv, lock, rblk, tz, irq}, 32'h0);
		@(posedge i_clk);
		i_rst_b <= 1'b1;
		rd(mft_pkg::OFS_FAULT, mft_pkg::RST_FAULT);
		rd(mft_pkg::OFS_PIN1, mft_pkg::RST_PIN1);
		rd(mft_pkg::OFS_PIN2, mft_pkg::RST_PIN2);
		rd(mft_pkg::OFS_PERIPH, mft_pkg::RST_PERIPH);
		rd(mft_pkg::OFS_IEN, 32'h0);
		@(posedge i_clk);
		run <= 1'b1;
		wr(mft_pkg::OFS_IEN, 32'h8);
		wr(mft_pkg::OFS_FAULT, f(1, mft_pkg::F_SYNC_CNT));
		for (int k = 0; k < 4; k++) begin
			ev(3'b010, 16'h03E8, 12'hFFF, 1'b0);
		end
		for (int c = 0; c < 8; c++) begin
			wr(mft_pkg::OFS_FAULT, f(1, mft_pkg::F_SYNC_EN) | f(c, mft_pkg::F_SYNC_CNT));
			for (int k = 0; k < c + 2; k++) begin
				ev(3'b010, 16'h03E8, 12'hFFF, k == c + 1);
			end
		end
		chk("irq", {31'h0, irq}, 32'h1);
		rd(mft_pkg::OFS_STAT, 32'h8);
		wr(mft_pkg::OFS_IEN, 32'h0);
		#1;
		chk("mask", {31'h0, irq}, 32'h0);
		wr(mft_pkg::OFS_CLR, 32'h8);
		rd(mft_pkg::OFS_STAT, 32'h0);
		for (int n = 0; n < 16; n++) begin
			wr(mft_pkg::OFS_FAULT, f(1, mft_pkg::F_ABN_EN) | f(n, mft_pkg::F_ABN_THR) |
				f(3, mft_pkg::F_RATIO));
			clr_prev();
			ev(3'b100, 16'((n + 1) * 2500), 12'hFFF, 1'b0);
			ev(3'b100, 16'((n + 1) * 2500 + 1), 12'hFFF, 1'b1);
		end
		for (int c = 0; c < 4; c++) begin
			wr(mft_pkg::OFS_FAULT, f(1, mft_pkg::F_ABN_EN) | f(15, mft_pkg::F_ABN_THR) |
				f(c, mft_pkg::F_RATIO));
			for (int k = 0; k < 2; k++) begin
				clr_prev();
				ev(3'b100, 16'h03E8, 12'hFFF, 1'b0);
				ev(3'b100, 16'(2000 * (c + 1) + k), 12'hFFF, k == 1);
			end
		end
		for (int c = 0; c < 8; c++) begin
			wr(mft_pkg::OFS_FAULT, f(1, mft_pkg::F_NOMTR_EN) | f(c, mft_pkg::F_NOMTR) |
				f(c, mft_pkg::F_MINSPD));
			ev(3'b100, 16'(ms[c]), 12'(nm[c]), 1'b0);
			ev(3'b100, 16'(ms[c]), 12'(nm[c] - 1), 1'b1);
			ev(3'b100, 16'(ms[c] - 1), 12'(nm[c]), 1'b1);
		end
		wr(mft_pkg::OFS_FAULT, 32'h0);
		ev(3'b100, 16'h03E8, 12'h000, 1'b0);
		lvl(1023, 500, 3'b000);
		lvl(0, 500, 3'b000);
		for (int c = 1; c < 8; c++) begin
			wr(mft_pkg::OFS_FAULT, f(1, mft_pkg::F_OV_MODE) | f(c, mft_pkg::F_OV) |
				f(1, mft_pkg::F_UV_MODE) | f(c, mft_pkg::F_UV));
			lvl(ovt[c], 500, 3'b000);
			lvl(ovt[c] + 1, 500, 3'b100);
			lvl(uvt[c], 500, 3'b000);
			lvl(uvt[c] - 1, 500, 3'b010);
			lvl(uvt[c], 500, 3'b000);
		end
		// Latched faults survive the supply coming back
		wr(mft_pkg::OFS_FAULT, f(1, mft_pkg::F_OV) | f(1, mft_pkg::F_UV));
		lvl(101, 500, 3'b100);
		lvl(60, 500, 3'b100);
		wr(mft_pkg::OFS_CLR, 32'h1);
		lvl(49, 500, 3'b010);
		lvl(60, 500, 3'b010);
		wr(mft_pkg::OFS_CLR, 32'h2);
		lvl(60, 500, 3'b000);
		for (int c = 0; c < 4; c++) begin
			wr(mft_pkg::OFS_FAULT, f(c, mft_pkg::F_DUTY));
			lvl(240, dt[c], 3'b000);
			lvl(240, (c > 0) ? dt[c] - 1 : 0, (c > 0) ? 3'b001 : 3'b000);
		end
		for (int c = 0; c < 8; c++) begin
			wr(mft_pkg::OFS_FAULT, f(c, mft_pkg::F_RETRY));
			wr(mft_pkg::OFS_CLR, 32'h40);
			for (int k = 0; k < 21; k++) begin
				ev(3'b001, 16'h03E8, 12'hFFF, 1'b0);
				@(posedge i_clk);
				#1;
				chk("retry", {31'h0, rblk}, {31'h0, c != 0 && k + 1 >= rt[c]});
			end
		end
		conclude();
	end
endmodule
`default_nettype wire
